// >>> lld_pkg.sv
package lld_pkg;
   // ==========================================================
   // descriptor memory geometry
   localparam int DESC_COUNT = 1024;
   localparam int DESC_WORDS = 8;
   localparam logic [15:0] DESC_STRIDE = 16'h0020;
   localparam logic [15:0] DESC_LAST = 16'h7FE0;
   // word offsets inside one descriptor
   localparam logic [4:0] W_OPTIONS = 5'h00;
   localparam logic [4:0] W_COUNT = 5'h04;
   localparam logic [4:0] W_TGT_LO = 5'h08;
   localparam logic [4:0] W_TGT_HI = 5'h0C;
   localparam logic [4:0] W_SIDE_LO = 5'h10;
   localparam logic [4:0] W_SIDE_HI = 5'h14;
   localparam logic [4:0] W_STRIDE = 5'h18;
   localparam logic [4:0] W_SUCC = 5'h1C;
   // ==========================================================
   // options word fields
   localparam int OPT_REPEAT_MODE = 3;
   localparam int OPT_END_ON_PKT = 7;
   localparam int OPT_CHAIN_LAST = 10;
   localparam int OPT_REPEAT_LO = 16;
   localparam int OPT_REPEAT_HI = 31;
   // ==========================================================
   // control window registers
   localparam logic [7:0] CTL_SEQ = 8'h00;
   localparam logic [7:0] CTL_STATUS = 8'h04;
   localparam logic [7:0] CTL_FIRST = 8'h08;
   localparam logic [7:0] CTL_CUR_TGT = 8'h0C;
   localparam int SEQ_GO_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> lld_word_ram.sv
`timescale 1ns/10ps
// =============================================================
// descriptor word memory, one write and two read ports
module lld_word_ram #(
   parameter int DEPTH = 8192,
   parameter int AW = 13
) (
   input wire logic aclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic [AW-1:0] raddr_a,
   output logic [31:0] rdata_a,
   input wire logic [AW-1:0] raddr_b,
   output logic [31:0] rdata_b
);
   logic [31:0] mem [DEPTH]; // storage array

   // byte-lane write and registered reads
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (we && wstrb[i])
         begin
            mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
         end
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end
endmodule // lld_word_ram

// >>> lld_store.sv
`timescale 1ns/10ps
// Operation
// - memory holds up to 1024 descriptors
// - separate control and descriptor address windows
// - descriptor n at n times 0x20
// - word 0 is the options word
// - word 1 is the byte count
// - word 2 is target address low
// - word 3 is target address high
// - words 4,5 form side-info address
// - repeat mode adds stride before each further pass
// - word 7 low half is successor
// - repeat link count times in repeat mode
// - chain-last bit stops following successors
// - end-on-packet bit selects transfer end
module lld_store #(
   parameter int NDESC = 1024,
   parameter int AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic link_done,
   output logic link_run,
   output logic [31:0] link_byte_count,
   output logic [63:0] link_target,
   output logic [63:0] link_side_info,
   output logic [31:0] link_options,
   output logic link_end_on_packet,
   output logic chain_done
);
   // ==========================================================
   // address windows: bit 15 selects the descriptor window
   localparam int WA = $clog2(NDESC * lld_pkg::DESC_WORDS);
   localparam logic [15:0] DESC_BASE = 16'h8000; // descriptor window base

   // ==========================================================
   // write channel capture
   logic aw_held; // address captured
   logic w_held; // data captured
   logic [AW-1:0] aw_addr; // held write address
   logic [31:0] w_data; // held write data
   logic [3:0] w_strb; // held strobes
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire wr_desc = aw_addr[15];
   wire ctl_hit_w = aw_addr[14:8] == 7'h00; // control window spans only 256 bytes
   wire wr_ctl = !aw_addr[15] && ctl_hit_w && (aw_addr[7:0] == lld_pkg::CTL_SEQ
      || aw_addr[7:0] == lld_pkg::CTL_FIRST);

   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;

   // capture address and data in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lld_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_desc || wr_ctl) ? lld_pkg::RESP_OKAY : lld_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // descriptor memory, word index = byte offset / 4
   logic [WA-1:0] rd_word; // bus read word index
   logic [WA-1:0] seq_word; // sequencer fetch word index
   logic [31:0] bus_word; // bus read result
   logic [31:0] seq_rword; // fetched descriptor word

   lld_word_ram #(
      .DEPTH(NDESC * lld_pkg::DESC_WORDS),
      .AW(WA)
   ) u_ram (
      .aclk(aclk),
      .we(do_write && wr_desc),
      .waddr(aw_addr[WA+1:2]),
      .wdata(w_data),
      .wstrb(w_strb),
      .raddr_a(rd_word),
      .rdata_a(bus_word),
      .raddr_b(seq_word),
      .rdata_b(seq_rword)
   );

   // ==========================================================
   // control registers
   logic seq_go; // software start request
   logic [15:0] first_link; // first descriptor byte offset
   logic busy; // sequencer running

   // start bit and first-link pointer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         seq_go <= 1'b0;
         first_link <= 16'h0000;
      end
      else if (do_write && wr_ctl && aw_addr[7:0] == lld_pkg::CTL_SEQ)
      begin
         seq_go <= w_data[lld_pkg::SEQ_GO_BIT];
      end
      else if (do_write && wr_ctl)
      begin
         first_link <= w_data[15:0];
      end
      else if (busy)
      begin
         seq_go <= 1'b0; // self-clears once taken
      end
   end

   // ==========================================================
   // read channel: two-cycle answer through the memory
   logic rd_wait; // memory read in flight
   logic [AW-1:0] ar_addr; // held read address
   wire rd_desc = ar_addr[15];
   assign s_axi_arready = !rd_wait && !s_axi_rvalid;
   assign rd_word = s_axi_araddr[WA+1:2];

   // ==========================================================
   // sequencer state
   typedef enum logic [4:0] {
      LLD_IDLE = 5'b00001,
      LLD_FETCH = 5'b00010,
      LLD_LOAD = 5'b00100,
      LLD_RUN = 5'b01000,
      LLD_NEXT = 5'b10000
   } lld_state_t;
   lld_state_t state; // sequencer state
   lld_state_t next_state; // next state
   logic [15:0] cur_link; // current descriptor byte offset
   logic [3:0] fetch_idx; // word being fetched
   logic [15:0] repeat_left; // passes remaining
   logic [31:0] stride; // repeat stride
   logic [15:0] successor; // next descriptor offset

   wire [31:0] ctl_rd = (ar_addr[7:0] == lld_pkg::CTL_SEQ) ? {31'h0, seq_go}
      : (ar_addr[7:0] == lld_pkg::CTL_STATUS) ? {27'h0, state}
      : (ar_addr[7:0] == lld_pkg::CTL_FIRST) ? {16'h0, first_link}
      : (ar_addr[7:0] == lld_pkg::CTL_CUR_TGT) ? link_target[31:0]
      : 32'h0000_0000;
   // aliases above the 256-byte control window are refused, not mirrored
   wire ctl_ok = ar_addr[14:8] == 7'h00 && ar_addr[7:0] <= lld_pkg::CTL_CUR_TGT
      && ar_addr[1:0] == 2'h0;

   // read request and answer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_wait <= 1'b0;
         ar_addr <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= lld_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rd_wait <= 1'b1;
         ar_addr <= s_axi_araddr;
      end
      else if (rd_wait)
      begin
         rd_wait <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_desc ? bus_word : ctl_ok ? ctl_rd : 32'h0000_0000;
         s_axi_rresp <= (rd_desc || ctl_ok) ? lld_pkg::RESP_OKAY : lld_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // fetch address: descriptor base plus word offset
   assign seq_word = WA'({cur_link[14:5], 3'h0} + fetch_idx[2:0]);
   assign busy = state != LLD_IDLE;
   assign link_run = state == LLD_RUN;
   assign link_end_on_packet = link_options[lld_pkg::OPT_END_ON_PKT];
   wire repeat_mode = link_options[lld_pkg::OPT_REPEAT_MODE];
   wire chain_last = link_options[lld_pkg::OPT_CHAIN_LAST];
   wire more_passes = repeat_mode && repeat_left > 16'h0001;

   // next state selection
   always_comb
   begin
      next_state = state;
      case (state)
         LLD_IDLE: if (seq_go) next_state = LLD_FETCH;
         LLD_FETCH: next_state = LLD_LOAD;
         LLD_LOAD: if (fetch_idx == 4'h8) next_state = LLD_RUN;
         LLD_RUN: if (link_done) next_state = LLD_NEXT;
         LLD_NEXT:
         begin
            if (more_passes) next_state = LLD_RUN;
            else if (chain_last) next_state = LLD_IDLE;
            else next_state = LLD_FETCH;
         end
         default: next_state = LLD_IDLE;
      endcase
   end

   // state register and field capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= LLD_IDLE;
         cur_link <= 16'h0000;
         fetch_idx <= 4'h0;
         repeat_left <= 16'h0000;
         stride <= 32'h0000_0000;
         successor <= 16'h0000;
         link_options <= 32'h0000_0000;
         link_byte_count <= 32'h0000_0000;
         link_target <= 64'h0;
         link_side_info <= 64'h0;
         chain_done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         chain_done <= state == LLD_NEXT && !more_passes && chain_last;
         if (state == LLD_IDLE)
         begin
            cur_link <= first_link;
            fetch_idx <= 4'h0;
         end
         if (state == LLD_FETCH)
         begin
            fetch_idx <= 4'h1; // word 0 is in flight
         end
         if (state == LLD_LOAD)
         begin
            fetch_idx <= fetch_idx + 4'h1;
            case (fetch_idx - 4'h1)
               4'h0: link_options <= seq_rword;
               4'h1: link_byte_count <= seq_rword;
               4'h2: link_target[31:0] <= seq_rword;
               4'h3: link_target[63:32] <= seq_rword;
               4'h4: link_side_info[31:0] <= seq_rword;
               4'h5: link_side_info[63:32] <= seq_rword;
               4'h6: stride <= seq_rword;
               4'h7: successor <= seq_rword[15:0];
               default: ;
            endcase
            if (fetch_idx == 4'h2)
            begin
               repeat_left <= link_options[lld_pkg::OPT_REPEAT_HI:lld_pkg::OPT_REPEAT_LO];
            end
         end
         if (state == LLD_NEXT)
         begin
            fetch_idx <= 4'h0;
            if (more_passes)
            begin
               repeat_left <= repeat_left - 16'h0001;
               link_target <= link_target + {32'h0, stride};
            end
            else
            begin
               cur_link <= successor;
            end
         end
      end
   end

   // ==========================================================
   // checks
   repeat_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_NEXT && more_passes |=> state == LLD_RUN)
      else $error("repeat pass did not rerun link");
   stride_add_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_NEXT && more_passes |=> link_target == $past(link_target) + {32'h0, $past(stride)})
      else $error("target not advanced by stride");
   chain_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_NEXT && !more_passes && chain_last |=> state == LLD_IDLE && chain_done)
      else $error("chain end not honoured");
   succ_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_NEXT && !more_passes && !chain_last |=> state == LLD_FETCH
      && cur_link == $past(successor))
      else $error("successor not followed");
   load_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_FETCH |=> state == LLD_LOAD [*8] ##1 state == LLD_RUN)
      else $error("descriptor fetch length wrong");
   bresp_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid)
      else $error("write answer missing");
   rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid)
      else $error("read answer late");
   pkt_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_LOAD && fetch_idx == 4'h1
      |=> link_end_on_packet == $past(seq_rword[lld_pkg::OPT_END_ON_PKT]))
      else $error("end on packet flag wrong");
   opt_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_LOAD && fetch_idx == 4'h1 |=> link_options == $past(seq_rword))
      else $error("options word not loaded");
   count_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_LOAD && fetch_idx == 4'h2 |=> link_byte_count == $past(seq_rword))
      else $error("byte count not loaded");
   tgt_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_LOAD && fetch_idx == 4'h3 |=> link_target[31:0] == $past(seq_rword))
      else $error("target low not loaded");
   tgt_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_LOAD && fetch_idx == 4'h4 |=> link_target[63:32] == $past(seq_rword))
      else $error("target high not loaded");
   side_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state == LLD_LOAD && fetch_idx == 4'h5 |=> link_side_info[31:0] == $past(seq_rword))
      else $error("side info low not loaded");
   fetch_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
      int'(seq_word) < NDESC * 8)
      else $error("fetch outside memory");
endmodule // lld_store

// >>> lld_engine_model.sv
`timescale 1ns/10ps
// =============================================================
// transfer engine model: one link_done pulse per executed pass
module lld_engine_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic link_run,
   input wire logic [7:0] delay,
   output logic link_done
);
   logic prev_run; // link_run one edge ago
   int cnt; // cycles left before the pulse, -1 when idle
   // =============================================================
   // a new pass starts on a rise of link_run, answer delay+2 cycles after the rise
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link_done <= 1'b0;
         prev_run <= 1'b0;
         cnt <= -1;
      end
      else
      begin
         link_done <= 1'b0;
         prev_run <= link_run;
         if (link_run && !prev_run)
            cnt <= int'(delay); // pass seen, arm the answer
         else if (cnt > 0)
            cnt <= cnt - 1; // slow answer keeps counting
         else if (cnt == 0)
         begin
            link_done <= 1'b1; // one-cycle pass-finished pulse
            cnt <= -1;
         end
      end
   end
endmodule // lld_engine_model

// >>> linked_list_descriptor_store_test.sv
`timescale 1ns/10ps
// =============================================================
// bench for the descriptor store and its sequencer
module linked_list_descriptor_store_test;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, link_done, link_run;
   logic link_end_on_packet, chain_done;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, link_byte_count, link_options, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [63:0] link_target, link_side_info;
   logic [7:0] eng_delay; // engine answer delay
   int n_fail, n_compared;
   // descriptor 0: repeat mode, count 2, end on packet; successor 0x7FE0
   localparam logic [31:0] D0 [8] = '{32'h0002_0088, 32'h0000_0100, 32'hFFFF_FFF0,
      32'h0000_0001, 32'h1234_5678, 32'h9ABC_DEF0, 32'h0000_0020, 32'h0000_7FE0};
   // descriptor 1023: chain last, no repeat
   localparam logic [31:0] D1 [8] = '{32'h0000_0400, 32'h0000_0040, 32'hA000_0000,
      32'h0000_0000, 32'h0000_0004, 32'h0000_0003, 32'h0000_0010, 32'h0000_0000};
   localparam logic [15:0] B0 = 16'h8000; // descriptor 0 byte address
   localparam logic [15:0] B1 = 16'hFFE0; // descriptor 1023 byte address
   lld_store #(.NDESC(1024), .AW(16)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_done(link_done),
      .link_run(link_run), .link_byte_count(link_byte_count),
      .link_target(link_target), .link_side_info(link_side_info),
      .link_options(link_options), .link_end_on_packet(link_end_on_packet),
      .chain_done(chain_done));
   lld_engine_model ENG (.aclk(aclk), .aresetn(aresetn), .link_run(link_run),
      .delay(eng_delay), .link_done(link_done));
   // =============================================================
   // clock, 4 ns period
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // =============================================================
   // compare and report
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d, mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic timed_out();
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
      stop_test();
   endtask
   // =============================================================
   // axi4-lite master cycles
   task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      int i;
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100 && !done; i++)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0; // address taken
         if (wvalid && wready) wvalid <= 1'b0; // data taken
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) timed_out();
   endtask
   task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      bit done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100 && !done; i++)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0; // address taken
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
      if (!done) timed_out();
   endtask
   // =============================================================
   // scenario: fill descriptors 0 and 1023, read every word back
   task automatic test_readback();
      int k;
      for (k = 0; k < 8; k++)
      begin
         axi_write(B0 + 16'(k * 4), D0[k], rsp);
         check(rsp, lld_pkg::RESP_OKAY);
         axi_write(B1 + 16'(k * 4), D1[k], rsp);
         check(rsp, lld_pkg::RESP_OKAY);
      end
      for (k = 0; k < 8; k++)
      begin
         axi_read(B0 + 16'(k * 4), rd, rsp);
         check(rd, D0[k]);
         axi_read(B1 + 16'(k * 4), rd, rsp);
         check(rd, D1[k]);
      end
   endtask
   // scenario: address outside both windows is refused
   task automatic test_unmapped();
      axi_write(16'h4000, 32'hDEAD_BEEF, rsp);
      check(rsp, lld_pkg::RESP_SLVERR);
      axi_read(16'h4000, rd, rsp);
      check({rsp, rd}, {lld_pkg::RESP_SLVERR, 32'h0000_0000});
   endtask
   // one pass: wait for link_run, compare fields, wait for its end
   task automatic run_pass(input logic [31:0] opt, input logic [31:0] cnt,
      input logic [63:0] tgt, input logic [63:0] side, input bit last);
      int i;
      for (i = 0; i < 200 && link_run !== 1'b1; i++) @(posedge aclk);
      if (i == 200) timed_out();
      @(posedge aclk);
      check(link_options, opt);
      check(link_byte_count, cnt);
      check(link_target, tgt);
      check(link_side_info, side);
      check(link_end_on_packet, opt[7]);
      for (i = 0; i < 200 && (last ? chain_done : !link_run) !== 1'b1; i++) @(posedge aclk);
      if (i == 200) timed_out();
   endtask
   // scenario: two repeated passes of 0, then 1023 which ends the chain
   task automatic test_chain();
      axi_write({8'h00, lld_pkg::CTL_FIRST}, 32'h0000_0000, rsp);
      check(rsp, lld_pkg::RESP_OKAY);
      eng_delay <= 8'h00; // prompt answer first
      axi_write({8'h00, lld_pkg::CTL_SEQ}, 32'h0000_0001, rsp);
      check(rsp, lld_pkg::RESP_OKAY);
      run_pass(D0[0], D0[1], {D0[3], D0[2]}, {D0[5], D0[4]}, 0);
      eng_delay <= 8'h05; // then slow answers
      run_pass(D0[0], D0[1], {D0[3], D0[2]} + {32'h0, D0[6]}, {D0[5], D0[4]}, 0);
      run_pass(D1[0], D1[1], {D1[3], D1[2]}, {D1[5], D1[4]}, 1);
      repeat (20) @(posedge aclk);
      check(link_run, 1'b0);
      axi_read({8'h00, lld_pkg::CTL_STATUS}, rd, rsp);
      check(rd, 32'h0000_0001);
      // last link's target low stays visible in the control window
      axi_read({8'h00, lld_pkg::CTL_CUR_TGT}, rd, rsp);
      check({rsp, rd}, {lld_pkg::RESP_OKAY, D1[2]});
   endtask
   // =============================================================
   // main sequence
   initial
   begin
      n_fail = 0;
      n_compared = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 16'h0000;
      araddr = 16'h0000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      eng_delay = 8'h00;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      test_readback();
      test_unmapped();
      test_chain();
      stop_test();
   end
endmodule // linked_list_descriptor_store_test
